// File: hdl/ctc_pkg.sv
// ctc_pkg: register map, field layout and timing constants for the comparator/touch control block
// assumes a 10 MHz system clock and a plain strobe register port
package ctc_pkg;
  localparam int CTC_ADDR_W = 4;
  localparam int CTC_DATA_W = 32;
  localparam logic [3:0] CTC_REG_CTRL0 = 4'h0;
  localparam logic [3:0] CTC_REG_CTRL1 = 4'h4;
  localparam logic [3:0] CTC_REG_STAT = 4'h8;
  localparam logic [31:0] CTC_RST_VAL = 32'h0000_0000;
  // ctrl0 fields
  localparam int CTC_F_PSEL = 6;
  localparam int CTC_F_NSEL = 4;
  localparam int CTC_F_USHORT = 3;
  localparam int CTC_F_LSHORT = 8;
  localparam int CTC_F_SRC = 0;
  // ctrl1 fields
  localparam int CTC_F_HYST = 20;
  localparam int CTC_F_NODE = 16;
  localparam int CTC_F_INV = 7;
  localparam int CTC_F_HS = 6;
  localparam int CTC_F_ISHORT = 5;
  localparam int CTC_F_NOV = 4;
  localparam int CTC_F_TCH = 2;
  localparam int CTC_F_DGL = 1;
  localparam int CTC_F_EN = 0;
  // status fields
  localparam int CTC_F_RAW = 0;
  localparam int CTC_F_OUT = 1;
  localparam int CTC_F_CNT = 16;
  // ladder supply codes
  localparam logic [2:0] CTC_SRC_OFF = 3'h0;
  localparam logic [2:0] CTC_SRC_CP = 3'h1;
  localparam logic [2:0] CTC_SRC_SYS = 3'h2;
  localparam logic [2:0] CTC_SRC_CORE = 3'h4;
  // timing
  localparam int CTC_CLK_HZ = 10_000_000;
  localparam int CTC_DGL_NS = 2000;
  localparam int CTC_DGL_CYC = (CTC_DGL_NS * (CTC_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CTC_CNT_W = 16;
endpackage

// File: hdl/ctc_cond_if.sv
// ctc_cond_if: carries the raw result and conditioning controls to the filter
// assumes one clock domain
`timescale 1ns/100ps
interface ctc_cond_if;
  logic raw;
  logic dgl_en;
  logic filt;
  modport ctl (output raw, output dgl_en, input filt);
  modport flt (input raw, input dgl_en, output filt);
endinterface

// File: hdl/ctc_deglitch.sv
// ctc_deglitch: suppresses pulses shorter than the deglitch time or bypasses
// assumes raw input already synchronous to clk
`timescale 1ns/100ps
module ctc_deglitch
  import ctc_pkg::*;
#(
  parameter int CYC = CTC_DGL_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  ctc_cond_if.flt cif
);
  localparam int CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic held_r, held_nxt;

  //////////////////////////////////////////////////////////////////
  // counter qualified level
  always_comb begin
    cnt_nxt = cnt_r;
    held_nxt = held_r;
    if (cif.raw == held_r) begin
      cnt_nxt = '0;
    end else if (cnt_r == CW'(CYC - 1)) begin
      cnt_nxt = '0;
      held_nxt = cif.raw;
    end else begin
      cnt_nxt = cnt_r + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      held_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      held_r <= held_nxt;
    end
  end

  assign cif.filt = cif.dgl_en ? held_r : cif.raw;
endmodule

// File: hdl/ctc_nonoverlap.sv
// ctc_nonoverlap: break-before-make sequencer for the two touch switches
// assumes the touch timer clock arrives as a synchronous level on clk
`timescale 1ns/100ps
module ctc_nonoverlap
  import ctc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic enable,
  input wire logic tclk,
  output logic chg_sw,
  output logic xfer_sw
);
  typedef enum logic [1:0] {CTC_IDLE, CTC_CHG, CTC_GAP, CTC_XFER} ctc_nov_t;
  ctc_nov_t st_r, st_nxt;
  logic tclk_r, tclk_nxt;
  logic edge_w;

  assign edge_w = tclk & ~tclk_r;

  //////////////////////////////////////////////////////////////////
  // steps on touch timer rising edges, except GAP which moves to XFER after one cycle
  always_comb begin
    tclk_nxt = tclk;
    st_nxt = st_r;
    if (!enable) begin
      st_nxt = CTC_IDLE;
    end else begin
      case (st_r)
        CTC_IDLE: st_nxt = edge_w ? CTC_CHG : CTC_IDLE;
        CTC_CHG: st_nxt = edge_w ? CTC_GAP : CTC_CHG;
        // one dead cycle so the open switch settles first
        CTC_GAP: st_nxt = CTC_XFER;
        CTC_XFER: st_nxt = edge_w ? CTC_IDLE : CTC_XFER;
        default: st_nxt = CTC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= CTC_IDLE;
      tclk_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      tclk_r <= tclk_nxt;
    end
  end

  assign chg_sw = (st_r == CTC_CHG);
  assign xfer_sw = (st_r == CTC_XFER);
endmodule

// File: hdl/ctc_top.sv
// ctc_top: digital control around the comparator, ladder and touch switches
// assumes comparator result and touch timer clock are synchronous to clk
//
// Function
// - input_short closes the switch joining positive and negative inputs.
// - two-bit fields select positive and negative comparator sources.
// - separate touch channel field selects the charged pad.
// - four-bit node select picks one of 16 middle ladder taps.
// - upper and lower short controls bypass the outer ladder segments.
// - source select connects ladder top to chosen supply.
// - masked node bits follow the comparator result for hysteresis.
// - unmasked node bits keep their programmed value.
// - deglitch enable filters pulses below 2 us, else bypass.
// - output invert flips the presented result.
// - conditioned result drives port1 bit 7; software sets it output.
// - interrupt request raised whenever the conditioned result changes while enabled.
// - charge and transfer switches never closed together.
// - switching rate taken from the touch timer clock.
// - touch timer counts time sense input exceeds ladder tap.
// - non-overlap disabled holds both switches open.
// - source codes 000 off, 001 pump, 010 system, 100 core.
`timescale 1ns/100ps
module ctc_top
  import ctc_pkg::*;
#(
  parameter int DGL_CYC = CTC_DGL_CYC,
  parameter int CNT_W = CTC_CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [CTC_ADDR_W-1:0] addr,
  input wire logic [CTC_DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [CTC_DATA_W-1:0] rdata,
  input wire logic cmp_result,
  input wire logic touch_timer_clock,
  input wire logic touch_timer_run,
  input wire logic touch_timer_clear,
  output logic [1:0] cmp_pos_select,
  output logic [1:0] cmp_neg_select,
  output logic [1:0] touch_channel_select,
  output logic input_short,
  output logic [3:0] ladder_tap_node,
  output logic ladder_upper_short,
  output logic ladder_lower_short,
  output logic src_charge_pump_supply,
  output logic src_system_supply,
  output logic src_core_supply,
  output logic cmp_enable,
  output logic high_speed,
  output logic port1_bit7,
  output logic comparator_irq_vector,
  output logic chg_sw_r,
  output logic xfer_sw_r,
  output logic [CNT_W-1:0] touch_count
);
  logic [31:0] c0_r, c0_nxt, c1_r, c1_nxt;
  logic [CTC_DATA_W-1:0] rd_r, rd_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic res_r, res_nxt;
  logic irq_r, irq_nxt;
  logic [3:0] node_r, node_nxt;
  logic [2:0] src_hot_r, src_hot_nxt;
  logic p7_r, p7_nxt;
  logic chg_w, xfer_w, chg_q, xfer_q;
  logic [3:0] node_w;
  logic [3:0] hyst_w, prog_w;
  logic cond_w;
  ctc_cond_if cif ();

  //////////////////////////////////////////////////////////////////
  // register port
  always_comb begin
    c0_nxt = c0_r;
    c1_nxt = c1_r;
    rd_nxt = '0;
    if (wr && addr == CTC_REG_CTRL0) begin
      c0_nxt = wdata;
    end
    if (wr && addr == CTC_REG_CTRL1) begin
      c1_nxt = wdata;
    end
    if (rd) begin
      case (addr)
        CTC_REG_CTRL0: rd_nxt = c0_r;
        CTC_REG_CTRL1: rd_nxt = c1_r;
        CTC_REG_STAT: begin
          rd_nxt[CTC_F_RAW] = cmp_result;
          rd_nxt[CTC_F_OUT] = p7_r;
          rd_nxt[CTC_F_CNT +: CNT_W] = cnt_r;
        end
        default: rd_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c0_r <= CTC_RST_VAL;
      c1_r <= CTC_RST_VAL;
      rd_r <= '0;
    end else if (ce) begin
      c0_r <= c0_nxt;
      c1_r <= c1_nxt;
      rd_r <= rd_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////
  // result conditioning
  assign cif.raw = cmp_result & c1_r[CTC_F_EN];
  assign cif.dgl_en = c1_r[CTC_F_DGL];

  ctc_deglitch #(.CYC(DGL_CYC)) u_dgl (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .cif(cif.flt)
  );

  assign cond_w = cif.filt ^ c1_r[CTC_F_INV];

  assign hyst_w = c1_r[CTC_F_HYST +: 4];
  assign prog_w = c1_r[CTC_F_NODE +: 4];
  assign node_w = (hyst_w & {4{cmp_result}}) | (~hyst_w & prog_w);

  // nonoverlap sequencer outputs registered again below
  ctc_nonoverlap u_nov (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .enable(c1_r[CTC_F_NOV]),
    .tclk(touch_timer_clock),
    .chg_sw(chg_w),
    .xfer_sw(xfer_w)
  );

  //////////////////////////////////////////////////////////////////
  // outputs and touch count
  always_comb begin
    node_nxt = node_w;
    p7_nxt = cond_w;
    res_nxt = cond_w;
    // every new result while enabled raises a request pulse
    irq_nxt = c1_r[CTC_F_EN] & (cond_w != res_r);
    // only the three legal codes connect a supply
    src_hot_nxt = 3'h0;
    case (c0_r[CTC_F_SRC +: 3])
      CTC_SRC_CP: src_hot_nxt[0] = 1'b1;
      CTC_SRC_SYS: src_hot_nxt[1] = 1'b1;
      CTC_SRC_CORE: src_hot_nxt[2] = 1'b1;
      default: src_hot_nxt = 3'h0;
    endcase
    cnt_nxt = cnt_r;
    if (touch_timer_clear) begin
      cnt_nxt = '0;
    end else if (touch_timer_run && cond_w) begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
    // break before make at the pins too
    chg_q = chg_w & ~xfer_sw_r;
    xfer_q = xfer_w & ~chg_sw_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      node_r <= '0;
      p7_r <= 1'b0;
      res_r <= 1'b0;
      irq_r <= 1'b0;
      src_hot_r <= 3'h0;
      cnt_r <= '0;
      chg_sw_r <= 1'b0;
      xfer_sw_r <= 1'b0;
    end else if (ce) begin
      node_r <= node_nxt;
      p7_r <= p7_nxt;
      res_r <= res_nxt;
      irq_r <= irq_nxt;
      src_hot_r <= src_hot_nxt;
      cnt_r <= cnt_nxt;
      chg_sw_r <= chg_q;
      xfer_sw_r <= xfer_q;
    end
  end

  //////////////////////////////////////////////////////////////////
  // field fan-out, all from flip-flops
  assign rdata = rd_r;
  assign cmp_pos_select = c0_r[CTC_F_PSEL +: 2];
  assign cmp_neg_select = c0_r[CTC_F_NSEL +: 2];
  assign touch_channel_select = c1_r[CTC_F_TCH +: 2];
  assign input_short = c1_r[CTC_F_ISHORT];
  assign ladder_tap_node = node_r;
  assign ladder_upper_short = c0_r[CTC_F_USHORT];
  assign ladder_lower_short = c0_r[CTC_F_LSHORT];
  // supply decode, other codes leave it off
  assign src_charge_pump_supply = src_hot_r[0];
  assign src_system_supply = src_hot_r[1];
  assign src_core_supply = src_hot_r[2];
  assign cmp_enable = c1_r[CTC_F_EN];
  assign high_speed = c1_r[CTC_F_HS];
  assign port1_bit7 = p7_r;
  assign comparator_irq_vector = irq_r;
  assign touch_count = cnt_r;
endmodule

// File: bench/ctc_top_properties.sv
// ctc_top_properties: port-level checks on ctc_top
// assumes one clk domain and rst_n asynchronous, active low
`timescale 1ns/100ps
module ctc_top_properties
  import ctc_pkg::*;
#(
  parameter int DGL_CYC = 20,
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rd,
  input wire logic [CTC_DATA_W-1:0] rdata,
  input wire logic touch_timer_run,
  input wire logic touch_timer_clear,
  input wire logic src_charge_pump_supply,
  input wire logic src_system_supply,
  input wire logic src_core_supply,
  input wire logic port1_bit7,
  input wire logic comparator_irq_vector,
  input wire logic chg_sw_r,
  input wire logic xfer_sw_r,
  input wire logic [CNT_W-1:0] touch_count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  a_sw_exclusive: assert property (!(chg_sw_r && xfer_sw_r))
    else $error("both touch switches closed");
  a_break_make: assert property ($rose(xfer_sw_r) |-> !$past(chg_sw_r))
    else $error("transfer closed with no open gap");
  a_src_onehot: assert property ($onehot0({src_charge_pump_supply, src_system_supply, src_core_supply}))
    else $error("two ladder supplies at once");
  a_irq_change: assert property ($rose(comparator_irq_vector) |-> $changed(port1_bit7) or ##1 $changed(port1_bit7))
    else $error("irq without result change");
  a_count_hold: assert property (!touch_timer_run && !touch_timer_clear |=> $stable(touch_count))
    else $error("count moved while stopped");
  a_count_clear: assert property (touch_timer_clear |=> touch_count == '0)
    else $error("count not cleared");
  a_count_step: assert property (!touch_timer_clear |=>
    touch_count == $past(touch_count) || touch_count == $past(touch_count) + 1'b1)
    else $error("count stepped by more than one");
  // read data only in the cycle after a read
  a_rdata_idle: assert property (!$past(rd) |-> rdata == '0)
    else $error("read data outside answer cycle");
  c_xfer: cover property ($rose(xfer_sw_r));
  c_irq: cover property ($rose(comparator_irq_vector));
  c_count: cover property (touch_count == 16'h000a);
endmodule
bind ctc_top ctc_top_properties #(.DGL_CYC(DGL_CYC), .CNT_W(CNT_W)) i_props (.clk, .rst_n, .rd, .rdata,
  .touch_timer_run, .touch_timer_clear, .src_charge_pump_supply, .src_system_supply, .src_core_supply,
  .port1_bit7, .comparator_irq_vector, .chg_sw_r, .xfer_sw_r, .touch_count);

// File: bench/ctc_analog_model.sv
// ctc_analog_model: comparator core and touch timer clock stand-in
// assumes the bench commands the comparison level
`timescale 1ns/100ps
module ctc_analog_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic level,
  input wire logic tclk_run,
  output logic cmp_result,
  output logic touch_timer_clock
);
  logic [1:0] div_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 2'h0;
      cmp_result <= 1'b0;
    end else begin
      div_r <= tclk_run ? div_r + 2'h1 : 2'h0;
      cmp_result <= level;
    end
  end
  // stands low while the timer is stopped
  assign touch_timer_clock = div_r[1];
endmodule

// File: bench/ctc_top_bench.sv
// ctc_top_bench: directed tests of ctc_top over its register port
// assumes ctc_analog_model on the far side, DGL_CYC shortened to 3
`timescale 1ns/100ps
module ctc_top_bench
  import ctc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic level = 1'b0;
  logic tclk_run = 1'b0;
  logic run = 1'b0;
  logic clear = 1'b0;
  logic [31:0] rdata;
  logic cmp_result, tclk, p_short, ush, lsh, s_cp, s_sys, s_core, en_o, hs, p17, irq, chg, xfer;
  logic [1:0] psel, nsel, tch;
  logic [3:0] node;
  logic [15:0] cnt;
  int num_errors = 0;
  int check_count = 0;
  int irq_count = 0;
  always #50 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) irq_count++;
  ctc_analog_model i_far (.clk(clk), .rst_n(rst_n), .level(level), .tclk_run(tclk_run),
    .cmp_result(cmp_result), .touch_timer_clock(tclk));
  ctc_top #(.DGL_CYC(3), .CNT_W(16)) i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cmp_result(cmp_result),
    .touch_timer_clock(tclk), .touch_timer_run(run), .touch_timer_clear(clear),
    .cmp_pos_select(psel), .cmp_neg_select(nsel), .touch_channel_select(tch), .input_short(p_short),
    .ladder_tap_node(node), .ladder_upper_short(ush), .ladder_lower_short(lsh),
    .src_charge_pump_supply(s_cp), .src_system_supply(s_sys), .src_core_supply(s_core),
    .cmp_enable(en_o), .high_speed(hs), .port1_bit7(p17), .comparator_irq_vector(irq),
    .chg_sw_r(chg), .xfer_sw_r(xfer), .touch_count(cnt));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_reg(CTC_REG_CTRL0, CTC_RST_VAL);
    rd_reg(CTC_REG_CTRL1, CTC_RST_VAL);
    chk({chg, xfer, p_short, p17, irq, s_cp, s_sys, s_core}, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_ladder;
    logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};
    foreach (codes[i]) begin
      wr_reg(CTC_REG_CTRL0, 32'h0000_0198 | codes[i]);
      cyc(1);
      chk({s_core, s_sys, s_cp}, (codes[i] inside {CTC_SRC_CP, CTC_SRC_SYS, CTC_SRC_CORE}) ? codes[i] : 3'h0);
    end
    chk({psel, nsel, ush, lsh}, 6'h27);
    rd_reg(CTC_REG_CTRL0, 32'h0000_019b);
    rd_reg(4'hc, 32'h0);
    wr_reg(CTC_REG_CTRL1, 32'h0000_006c);
    chk({p_short, tch, hs}, 4'hf);
    wr_reg(CTC_REG_CTRL1, 32'h0000_0000);
    chk({p_short, tch}, 3'h0);
    $display("ladder test done");
  endtask
  task automatic t_hyst;
    for (int k = 0; k < 4; k++) begin
      wr_reg(CTC_REG_CTRL1, k[1] ? 32'h005f_0001 : 32'h0006_0001);
      level <= k[0];
      cyc(4);
      chk(node, k[1] ? (4'ha | (4'h5 & {4{k[0]}})) : 4'h6);
    end
    $display("hysteresis test done");
  endtask
  task automatic t_result;
    int base;
    for (int k = 0; k < 4; k++) begin
      wr_reg(CTC_REG_CTRL1, k[1] ? 32'h0000_0081 : 32'h0000_0001);
      base = irq_count;
      level <= k[0];
      cyc(4);
      chk(p17, k[0] ^ k[1]);
      chk(irq_count != base, 1'b1);
    end
    base = irq_count;
    cyc(6);
    chk(irq_count, base);
    $display("result test done");
  endtask
  task automatic t_deglitch;
    wr_reg(CTC_REG_CTRL1, 32'h0000_0003);
    level <= 1'b0;
    cyc(10);
    level <= 1'b1;
    cyc(2);
    level <= 1'b0;
    cyc(8);
    chk(p17, 1'b0);
    level <= 1'b1;
    cyc(8);
    chk(p17, 1'b1);
    $display("deglitch test done");
  endtask
  task automatic t_switch;
    logic sc, sx;
    wr_reg(CTC_REG_CTRL1, 32'h0000_0011);
    sc = 0;
    sx = 0;
    repeat (40) begin
      cyc(1);
      sc |= chg;
      sx |= xfer;
    end
    chk({sc, sx}, 2'b00);
    tclk_run <= 1'b1;
    repeat (60) begin
      cyc(1);
      sc |= chg;
      sx |= xfer;
    end
    chk({sc, sx}, 2'b11);
    wr_reg(CTC_REG_CTRL1, 32'h0000_0001);
    cyc(2);
    chk({chg, xfer}, 2'b00);
    tclk_run <= 1'b0;
    $display("switch test done");
  endtask
  task automatic t_count;
    level <= 1'b1;
    cyc(5);
    run <= 1'b1;
    clear <= 1'b1;
    cyc(1);
    clear <= 1'b0;
    cyc(10);
    run <= 1'b0;
    cyc(2);
    chk(cnt, 16'h000a);
    rd_reg(CTC_REG_STAT, 32'h000a_0003);
    $display("count test done");
  endtask
  task automatic t_freeze;
    cyc(1);
    ce <= 1'b0;
    wr_reg(CTC_REG_CTRL1, 32'h0000_0080);
    ce <= 1'b1;
    rd_reg(CTC_REG_CTRL1, 32'h0000_0001);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    rd_reg(CTC_REG_CTRL1, CTC_RST_VAL);
    chk({cnt, p17, irq}, 32'h0);
    $display("freeze and reset test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_ladder();
    t_hyst();
    t_result();
    t_deglitch();
    t_switch();
    t_count();
    t_freeze();
    final_report();
  end
endmodule
